// File: hw/cdrs_top.sv
// Clock divide and reset sequencer with Wishbone registers
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module cdrs_top
	import cdrs_pkg::*;
#(
	parameter logic [OS_W-1:0] POR_TICKS = OS_W'(POR_TICKS_DEF),
	parameter logic [OS_W-1:0] WDT_TICKS = OS_W'(WDT_TICKS_DEF)
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             sys_rst,
	// Wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [WB_AW-1:0] wb_adr_i,
	input  wire logic [WB_SW-1:0] wb_sel_i,
	input  wire logic [WB_DW-1:0] wb_dat_i,
	output logic      [WB_DW-1:0] wb_dat_o,
	output logic                  wb_ack_o,
	// Pins
	input  wire logic             oscillator_input,
	input  wire logic             rc_oscillator,
	input  wire logic             power_good,
	input  wire logic [REG_W-1:0] port2_pins,
	input  wire logic [REG_W-1:0] port5_pins,
	// Core side
	input  wire logic             stop_mode,
	output logic                  sys_clk_en,
	output logic                  counter_clock_en,
	output logic                  core_reset,
	output logic                  irq
);
	logic [PIN_W-1:0] s1;
	logic [PIN_W-1:0] s2;
	logic [PIN_W-1:0] s3;
	logic [PIN_W-1:0] lvl;
	logic [PIN_W-1:0] lvl_q;
	logic [REG_W-1:0] stop_recovery_clock_control;
	logic [REG_W-1:0] p2sel;
	logic [REG_W-1:0] p5sel;
	logic [REG_W-1:0] stat;
	logic [REG_W-1:0] mask;
	logic             wdt_en;
	logic             wake_q;
	logic [REG_W-1:0] rd_byte;
	logic [REG_W-1:0] next_stat;

	cdrs_div_if div_if ();
	cdrs_os_if  por_if ();
	cdrs_os_if  wdt_if ();

	// Pin synchronisers; a change counts once stages two and three agree
	wire [PIN_W-1:0] pins = {rc_oscillator, oscillator_input,
		power_good, port5_pins, port2_pins};
	wire [PIN_W-1:0] moving = s2 ^ s3;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= pins;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lvl   <= '0;
			lvl_q <= '0;
		end else begin
			lvl   <= (s2 & ~moving) | (lvl & moving);
			lvl_q <= lvl;
		end
	end

	// Edges; both oscillators must run below a sixth of clock
	wire ext_tick = lvl[PIN_OSC] & ~lvl_q[PIN_OSC];
	wire rc_tick  = lvl[PIN_RC] & ~lvl_q[PIN_RC];
	wire pg_ok    = lvl[PIN_PG];
	wire pg_rise  = pg_ok & ~lvl_q[PIN_PG];
	wire cold     = ~pg_ok;

	// Stop-mode wake sources
	wire [REG_W-1:0] p2_lvl = lvl[PIN_P2 +: REG_W];
	wire [REG_W-1:0] p5_lvl = lvl[PIN_P5 +: REG_W];
	wire wake_hit  = stop_mode & (|(p2_lvl & p2sel) | |(p5_lvl & p5sel));
	wire wake_rise = wake_hit & ~wake_q;
	wire use_dly   = stop_recovery_clock_control[SMR_DLY];
	// Bypass holds reset only while the source stays active
	wire bypass    = wake_hit & ~use_dly;

	always_ff @(posedge clock) begin
		if (sys_rst)
			wake_q <= 1'b0;
		else
			wake_q <= wake_hit;
	end

	// Watchdog
	wire wr_kick;
	wire wdt_to  = wdt_if.done & wdt_en;
	wire por_go  = pg_rise | (wake_rise & use_dly) | wdt_to;

	assign wdt_if.tick  = rc_tick;
	assign wdt_if.start = wdt_en & (wr_kick | ~wdt_if.busy | core_reset);

	cdrs_oneshot #(
		.CW  (OS_W),
		.LEN (WDT_TICKS)
	) u_wdt (
		.clock   (clock),
		.sys_rst (sys_rst),
		.o       (wdt_if.cnt)
	);

	// Power-on delay, counted only by the RC oscillator
	assign por_if.tick  = rc_tick;
	assign por_if.start = por_go;

	cdrs_oneshot #(
		.CW  (OS_W),
		.LEN (POR_TICKS)
	) u_por (
		.clock   (clock),
		.sys_rst (sys_rst),
		.o       (por_if.cnt)
	);

	wire next_core_reset = cold | por_go | por_if.busy | bypass;

	always_ff @(posedge clock) begin
		if (sys_rst)
			core_reset <= 1'b1;
		else
			core_reset <= next_core_reset;
	end

	// Clock enables
	assign div_if.ext_tick = ext_tick;
	assign div_if.undiv    = stop_recovery_clock_control[SMR_UNDIV];
	assign div_if.pre16    = stop_recovery_clock_control[SMR_PRE16];

	cdrs_clkdiv u_div (
		.clock   (clock),
		.sys_rst (sys_rst),
		.d       (div_if.dv)
	);

	assign sys_clk_en       = div_if.clk_en;
	assign counter_clock_en = div_if.clk_en;

	// Wishbone decode; writes land on the edge that sees ack
	wire             req  = wb_cyc_i & wb_stb_i;
	wire [IDX_W-1:0] idx  = wb_adr_i[IDX_LSB +: IDX_W];
	wire [REG_W-1:0] wdat = wb_dat_i[REG_W-1:0];
	wire             wr   = req & wb_ack_o & wb_we_i & wb_sel_i[0];
	wire             wr_smr  = wr & (idx == IDX_SMR);
	wire             wr_p2   = wr & (idx == IDX_P2);
	wire             wr_p5   = wr & (idx == IDX_P5);
	wire             wr_ctrl = wr & (idx == IDX_CTRL);
	wire             wr_stat = wr & (idx == IDX_STAT);
	wire             wr_mask = wr & (idx == IDX_MASK);
	assign wr_kick = wr_ctrl & wdat[CTRL_KICK];

	wire [REG_W-1:0] ctrl_rd = (REG_W'(wdt_en) << CTRL_WDT_EN)
		| (REG_W'(wdt_if.busy) << CTRL_WDT_RUN);

	// Unmapped addresses read zero and ignore writes
	always_comb begin
		if (idx == IDX_SMR)
			rd_byte = stop_recovery_clock_control;
		else if (idx == IDX_P2)
			rd_byte = p2sel;
		else if (idx == IDX_P5)
			rd_byte = p5sel;
		else if (idx == IDX_CTRL)
			rd_byte = ctrl_rd;
		else if (idx == IDX_STAT)
			rd_byte = stat;
		else if (idx == IDX_MASK)
			rd_byte = mask;
		else
			rd_byte = ZERO_RST;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req & ~wb_ack_o)
				wb_dat_o <= WB_DW'(rd_byte);
		end
	end

	// Registers; power loss restores every default
	always_ff @(posedge clock) begin
		if (sys_rst || cold) begin
			stop_recovery_clock_control <= SMR_RST;
		end else begin
			if (wr_smr)
				stop_recovery_clock_control[SMR_WARM-1:0] <= wdat[SMR_WARM-1:0];
			if (wake_rise)
				stop_recovery_clock_control[SMR_WARM] <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || cold) begin
			p2sel  <= ZERO_RST;
			p5sel  <= ZERO_RST;
			mask   <= ZERO_RST;
			wdt_en <= 1'b0;
		end else begin
			if (wr_p2)
				p2sel <= wdat;
			if (wr_p5)
				p5sel <= wdat;
			if (wr_mask)
				mask <= wdat;
			if (wr_ctrl)
				wdt_en <= wdat[CTRL_WDT_EN];
		end
	end

	// Interrupt status, write one to clear, a new event wins
	wire [REG_W-1:0] events = (REG_W'(pg_rise) << ST_COLD)
		| (REG_W'(wake_rise) << ST_WAKE)
		| (REG_W'(wdt_to) << ST_WDT)
		| (REG_W'(por_if.done) << ST_DONE);
	wire [REG_W-1:0] clr = wr_stat ? wdat : ZERO_RST;

	assign next_stat = (stat & ~clr) | events;

	always_ff @(posedge clock) begin
		if (sys_rst || cold)
			stat <= ZERO_RST;
		else
			stat <= next_stat;
	end

	// Next mask too, so irq never lags a mask write
	wire [REG_W-1:0] next_mask = wr_mask ? wdat : mask;

	// Power loss clears status and mask, so irq drops with them
	always_ff @(posedge clock) begin
		if (sys_rst || cold)
			irq <= 1'b0;
		else
			irq <= |(next_stat & next_mask);
	end

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	cold_defaults_a: assert property (
		cold |=> stop_recovery_clock_control == SMR_RST && p2sel == ZERO_RST
			&& p5sel == ZERO_RST && mask == ZERO_RST)
		else $error("registers not at defaults after power loss");
	cold_flag_a: assert property (
		cold |=> !stop_recovery_clock_control[SMR_WARM])
		else $error("warm flag set after power loss");
	por_hold_a: assert property (
		por_if.busy |=> core_reset)
		else $error("core released during delay");
	pg_trigger_a: assert property (
		pg_rise |=> por_if.busy ##1 core_reset)
		else $error("power good did not start delay");
	wake_delay_a: assert property (
		wake_rise && use_dly |=> por_if.busy)
		else $error("wake did not start delay");
	wake_bypass_a: assert property (
		bypass && !por_if.busy && !por_go && pg_ok
			|=> !por_if.busy ##0 core_reset)
		else $error("bypass wake started delay");
	wdt_trigger_a: assert property (
		wdt_to |=> por_if.busy && stat[ST_WDT])
		else $error("watchdog timeout lost");
	wdt_kick_a: assert property (
		wr_kick && wdt_en |=> wdt_if.busy && !wdt_if.done)
		else $error("kick did not retrigger watchdog");
	rc_only_a: assert property (
		por_if.busy && !rc_tick && !por_go |=> por_if.busy)
		else $error("delay ended without an RC edge");
	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	stat_sticky_a: assert property (
		stat[ST_WAKE] && !(wr_stat && wdat[ST_WAKE]) && !cold
			|=> stat[ST_WAKE])
		else $error("wake status lost");
	irq_level_a: assert property (
		irq == |(stat & mask))
		else $error("irq does not follow status and mask");
	ack_answer_a: assert property (
		req && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	rd_stands_a: assert property (
		wb_ack_o |=> $stable(wb_dat_o))
		else $error("read data changed after ack");
	sel_ignore_a: assert property (
		req && wb_ack_o && wb_we_i && !wb_sel_i[0] && !cold
			|=> $stable(mask))
		else $error("write with low lane disabled landed");
	mask_write_a: assert property (
		wr_mask && !cold |=> mask == $past(wdat))
		else $error("mask write lost");
	ctrl_write_a: assert property (
		wr_ctrl && !cold |=> wdt_en == $past(wdat[CTRL_WDT_EN]))
		else $error("watchdog enable write lost");
	warm_ro_a: assert property (
		wr_smr && !wake_rise && !cold |=> $stable(stop_recovery_clock_control[SMR_WARM]))
		else $error("software changed the warm flag");
	wake_warm_a: assert property (
		wake_rise && !cold |=> stop_recovery_clock_control[SMR_WARM])
		else $error("wake did not set the warm flag");
	wake_stat_a: assert property (
		wake_rise && !cold |=> stat[ST_WAKE])
		else $error("wake event not recorded");
	done_stat_a: assert property (
		por_if.done && !cold |=> stat[ST_DONE])
		else $error("delay end not recorded");
	cold_hold_a: assert property (
		cold |=> core_reset)
		else $error("core released while power is bad");
	stat_clear_a: assert property (
		wr_stat && wdat[ST_WAKE] && !wake_rise |=> !stat[ST_WAKE])
		else $error("wake status not cleared by a one");
	por_release_a: assert property (
		por_if.done && !cold && !por_go && !bypass |=> !core_reset)
		else $error("core still held after the delay");

	cold_done_c: cover property (pg_rise ##[1:1000] por_if.done);
	wake_dly_c: cover property (wake_rise && use_dly);
	wake_byp_c: cover property (wake_rise && !use_dly);
	wdt_to_c: cover property (wdt_to);
	undiv_c: cover property (sys_clk_en && stop_recovery_clock_control[SMR_UNDIV]);
endmodule
`default_nettype wire

// File: hw/cdrs_pkg.sv
// Constants for the clock divide and reset sequencer
// How it works
// - Clock select zero gives external clock halved
// - Select bit one runs clocks undivided
// - Optional divide-by-16 prescaler, overall 32 possible
// - Cold start restores every register default
// - Cold start clears the warm-start flag
// - Delay timer counts the RC oscillator only
// - One-shot delay: power good, wake, watchdog
// - Wake uses delay only when bit five set
// - Watchdog retriggerable, resets at terminal count
// - Core held in reset during delay
package cdrs_pkg;
	// Bus and data widths
	localparam int WB_DW  = 32;
	localparam int WB_SW  = 4;
	localparam int WB_AW  = 6;
	localparam int REG_W  = 8;
	localparam int IDX_W  = 4;
	localparam int IDX_LSB = 2;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_P2   = 4'h1;
	localparam logic [IDX_W-1:0] IDX_CTRL = 4'h2;
	localparam logic [IDX_W-1:0] IDX_STAT = 4'h3;
	localparam logic [IDX_W-1:0] IDX_MASK = 4'h4;
	localparam logic [IDX_W-1:0] IDX_P5   = 4'h5;
	localparam logic [IDX_W-1:0] IDX_SMR  = 4'hB;
	// Reset values
	localparam logic [REG_W-1:0] SMR_RST  = 8'h20;
	localparam logic [REG_W-1:0] ZERO_RST = 8'h00;
	// Stop-recovery clock control fields
	localparam int SMR_PRE16 = 0;
	localparam int SMR_UNDIV = 1;
	localparam int SMR_DLY   = 5;
	localparam int SMR_WARM  = 7;
	// Own control register fields
	localparam int CTRL_WDT_EN  = 0;
	localparam int CTRL_KICK    = 1;
	localparam int CTRL_WDT_RUN = 2;
	// Interrupt status fields
	localparam int ST_COLD = 0;
	localparam int ST_WAKE = 1;
	localparam int ST_WDT  = 2;
	localparam int ST_DONE = 3;
	// Pin vector layout
	localparam int PIN_P2 = 0;
	localparam int PIN_P5 = 8;
	localparam int PIN_PG = 16;
	localparam int PIN_OSC = 17;
	localparam int PIN_RC = 18;
	localparam int PIN_W  = 19;
	// Divider
	localparam int PRE_W = 4;
	localparam logic [PRE_W-1:0] PRE_LAST = 4'hF;
	localparam int SLOW_DIV = 2;
	localparam int PRE_DIV  = 16;
	localparam int PER_W    = 6;
	// One-shot timers, counted in RC oscillator periods
	localparam int OS_W = 16;
	localparam int OS_LAST = 1;
	localparam int POR_TICKS_DEF = 1024;
	localparam int WDT_TICKS_DEF = 4096;
endpackage

// File: hw/cdrs_if.sv
// Carriers between the sequencer and its divider and timers
`timescale 1ns/100ps
`default_nettype none
interface cdrs_div_if;
	logic ext_tick;
	logic undiv;
	logic pre16;
	logic clk_en;
	modport ctl (output ext_tick, output undiv, output pre16, input clk_en);
	modport dv (input ext_tick, input undiv, input pre16, output clk_en);
endinterface

interface cdrs_os_if;
	logic tick;
	logic start;
	logic busy;
	logic done;
	modport ctl (output tick, output start, input busy, input done);
	modport cnt (input tick, input start, output busy, output done);
endinterface
`default_nettype wire

// File: hw/cdrs_clkdiv.sv
// Glitch-free system and counter clock enable divider
`timescale 1ns/100ps
`default_nettype none
module cdrs_clkdiv
	import cdrs_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Divider carrier
	cdrs_div_if.dv    d
);
	logic             half;
	logic             act_undiv;
	logic             act_pre;
	logic [PRE_W-1:0] pre_cnt;
	logic [PER_W-1:0] seen;

	wire base    = d.ext_tick & (act_undiv | half);
	wire pre_end = pre_cnt == PRE_LAST;
	assign d.clk_en = base & (~act_pre | pre_end);

	// New selection only taken at a period boundary
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			half      <= 1'b0;
			act_undiv <= 1'b0;
			act_pre   <= 1'b0;
			pre_cnt   <= '0;
		end else if (d.clk_en) begin
			half      <= 1'b0;
			act_undiv <= d.undiv;
			act_pre   <= d.pre16;
			pre_cnt   <= '0;
		end else if (d.ext_tick) begin
			half <= ~half;
			if (base)
				pre_cnt <= pre_cnt + 1'b1;
		end
	end

	// Helper for the period check
	always_ff @(posedge clock) begin
		if (sys_rst || d.clk_en)
			seen <= '0;
		else if (d.ext_tick)
			seen <= seen + 1'b1;
	end

	wire [PER_W-1:0] per_a = act_undiv ? PER_W'(1) : PER_W'(SLOW_DIV);
	wire [PER_W-1:0] exp_per = act_pre ? PER_W'(per_a * PRE_DIV) : per_a;

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	div_period_a: assert property (
		d.clk_en |-> (seen + 1'b1) == exp_per)
		else $error("clock enable period wrong");
	div_sel_hold_a: assert property (
		!d.clk_en |=> $stable(act_undiv) && $stable(act_pre))
		else $error("divide changed mid period");
	div_half_a: assert property (
		d.clk_en && !act_undiv && !act_pre |-> seen == PER_W'(1))
		else $error("divide by two period wrong");
endmodule
`default_nettype wire

// File: hw/cdrs_oneshot.sv
// Retriggerable one-shot counted by an external tick
`timescale 1ns/100ps
`default_nettype none
module cdrs_oneshot
	import cdrs_pkg::*;
#(
	parameter int            CW  = OS_W,
	parameter logic [CW-1:0] LEN = CW'(POR_TICKS_DEF)
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// Timer carrier
	cdrs_os_if.cnt    o
);
	logic [CW-1:0] cnt;

	// Start while running reloads the count
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt    <= '0;
			o.busy <= 1'b0;
			o.done <= 1'b0;
		end else begin
			o.done <= 1'b0;
			if (o.start) begin
				cnt    <= LEN;
				o.busy <= 1'b1;
			end else if (o.busy && o.tick) begin
				cnt <= cnt - 1'b1;
				if (cnt == CW'(OS_LAST)) begin
					o.busy <= 1'b0;
					o.done <= 1'b1;
				end
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	os_tick_only_a: assert property (
		o.busy && !o.tick && !o.start |=> $stable(cnt) && o.busy)
		else $error("timer moved without a tick");
	os_done_end_a: assert property (
		o.done |-> $past(o.busy) && !o.busy)
		else $error("timer end without a run");
endmodule
`default_nettype wire

// File: tb/cdrs_osc_model.sv
// Model of the external clock source and the on-chip RC oscillator
`timescale 1ns/100ps
`default_nettype none
module cdrs_osc_model #(
	parameter int EXT_HALF = 40,
	parameter int RC_HALF  = 50
) (
	// Oscillator pins
	output logic ext_clk,
	output logic rc_clk
);
	// Crystal runs free, eight system clocks a period
	initial begin
		ext_clk = 1'b0;
		#3;
		forever #EXT_HALF ext_clk = ~ext_clk;
	end
	// Own source, phase unrelated to the crystal
	initial begin
		rc_clk = 1'b0;
		#17;
		forever #RC_HALF rc_clk = ~rc_clk;
	end
endmodule
`default_nettype wire

// File: tb/tb_clock_divide_reset_sequencer.sv
// Self-checking bench for the clock divide and reset sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_clock_divide_reset_sequencer
	import cdrs_pkg::*;
;
	localparam int POR_T = 4;
	localparam int WDT_T = 16;
	// RC period in system clocks
	localparam int RC = 10;
	logic             clock = 1'b0;
	logic             sys_rst = 1'b1;
	logic             cyc = 1'b0;
	logic             stb = 1'b0;
	logic             we = 1'b0;
	logic [WB_AW-1:0] adr = 6'h00;
	logic [WB_SW-1:0] sel = 4'hF;
	logic [WB_DW-1:0] di = 32'h0;
	logic [WB_DW-1:0] dq;
	logic             ack;
	logic             ext;
	logic             rc;
	logic             pg = 1'b0;
	logic [7:0]       p2 = 8'h00;
	logic [7:0]       p5 = 8'h00;
	logic             stop = 1'b0;
	logic             sen;
	logic             cen;
	logic             crst;
	logic             irq;
	int               n_errors = 0;
	int               checks_done = 0;
	int               ticks = 0;
	// Register rows: address, reset value, write, readback
	logic [5:0] ra [5] = '{6'h04, 6'h14, 6'h2C, 6'h10, 6'h3C};
	logic [7:0] rr [5] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
	logic [7:0] rw [5] = '{8'h5A, 8'hA5, 8'hA3, 8'h0B, 8'hFF};
	logic [7:0] rb [5] = '{8'h5A, 8'hA5, 8'h23, 8'h0B, 8'h00};
	// Divider rows: control value, enable period in clocks
	logic [7:0] sm [5] = '{8'h20, 8'h22, 8'h21, 8'h23, 8'h20};
	int         sp [5] = '{16, 8, 256, 128, 16};

	always #5 clock = ~clock;

	cdrs_osc_model osc_u (
		.ext_clk (ext),
		.rc_clk  (rc)
	);

	cdrs_top #(
		.POR_TICKS (OS_W'(POR_T)),
		.WDT_TICKS (OS_W'(WDT_T))
	) dut_u (
		.clock            (clock),
		.sys_rst          (sys_rst),
		.wb_cyc_i         (cyc),
		.wb_stb_i         (stb),
		.wb_we_i          (we),
		.wb_adr_i         (adr),
		.wb_sel_i         (sel),
		.wb_dat_i         (di),
		.wb_dat_o         (dq),
		.wb_ack_o         (ack),
		.oscillator_input (ext),
		.rc_oscillator    (rc),
		.power_good       (pg),
		.port2_pins       (p2),
		.port5_pins       (p5),
		.stop_mode        (stop),
		.sys_clk_en       (sen),
		.counter_clock_en (cen),
		.core_reset       (crst),
		.irq              (irq)
	);

	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge clock);
	endtask

	// One classic cycle; entered just after a rising edge
	task automatic wb(input logic w, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		di <= {24'h0, d};
		do begin
			@(posedge clock);
			t++;
		end while (ack !== 1'b1 && t < 50);
		q = dq[7:0];
		chk("ack", 1'b1, ack);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		chk($sformatf("reg %0h", a), e, q);
	endtask

	// Cycles until core reset reaches v, capped at lim
	task automatic wt(input logic v, input int lim, output int c);
		c = 0;
		while (crst !== v && c < lim) begin
			@(posedge clock);
			c++;
		end
	endtask

	// Clocks between two enable pulses
	task automatic per(output int p);
		int t;
		t = 0;
		do begin
			@(posedge clock);
			t++;
		end while (sen !== 1'b1 && t < 600);
		p = 0;
		do begin
			@(posedge clock);
			p++;
		end while (sen !== 1'b1 && p < 600);
		chk("cnt_en", 1'b1, cen);
	endtask

	always @(posedge clock) begin
		ticks++;
		if (ticks == 20000) begin
			n_errors++;
			summarize();
		end
	end

	initial begin
		int c;
		int p;
		int prev;
		logic [7:0] q;
		tk(8);
		sys_rst <= 1'b0;
		tk(10);
		chk("hold_pg_low", 1'b1, crst);
		pg <= 1'b1;
		wt(1'b0, 500, c);
		chk("por_len", 1'b1, c >= (POR_T - 1) * RC);
		chk("por_max", 1'b1, c <= (POR_T + 1) * RC + 8);
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], rr[i]);
			wr(ra[i], rw[i]);
			rd(ra[i], rb[i]);
		end
		sel <= 4'hE;
		wr(6'h10, 8'hFF);
		sel <= 4'hF;
		rd(6'h10, 8'h0B);
		rd(6'h0C, 8'h09);
		wr(6'h10, 8'h01);
		tk(2);
		chk("irq_on", 1'b1, irq);
		wr(6'h0C, 8'h01);
		tk(2);
		chk("irq_clr", 1'b0, irq);
		rd(6'h0C, 8'h08);
		wr(6'h10, 8'h08);
		tk(2);
		chk("irq_done", 1'b1, irq);
		wr(6'h0C, 8'h08);
		tk(2);
		chk("irq_off", 1'b0, irq);
		prev = 128;
		for (int i = 0; i < 5; i++) begin
			wr(6'h2C, sm[i]);
			per(p);
			chk("edge_per", 1'b1, p >= (prev < sp[i] ? prev : sp[i]));
			per(p);
			chk("period", sp[i], p);
			prev = sp[i];
		end
		// Wake through the delay
		wr(6'h04, 8'h01);
		stop <= 1'b1;
		p2 <= 8'h01;
		wt(1'b1, 20, c);
		chk("wake_rst", 1'b1, crst);
		wt(1'b0, 500, c);
		chk("wake_dly", 1'b1, c >= (POR_T - 1) * RC);
		stop <= 1'b0;
		p2 <= 8'h00;
		rd(6'h2C, 8'hA0);
		rd(6'h0C, 8'h0A);
		wr(6'h0C, 8'h0A);
		// Wake with the delay bypassed
		wr(6'h2C, 8'h00);
		wr(6'h14, 8'h02);
		stop <= 1'b1;
		p5 <= 8'h02;
		tk(8);
		chk("byp_on", 1'b1, crst);
		tk(40);
		chk("byp_hold", 1'b1, crst);
		stop <= 1'b0;
		p5 <= 8'h00;
		tk(8);
		chk("byp_off", 1'b0, crst);
		wr(6'h2C, 8'h20);
		wr(6'h0C, 8'h0F);
		// Watchdog kicked, then left to expire
		wr(6'h08, 8'h01);
		wb(1'b0, 6'h08, 8'h00, q);
		chk("wdt_run", 1'b1, q[2]);
		chk("ctrl_rd", 8'h05, q);
		repeat (6) begin
			tk(60);
			wr(6'h08, 8'h03);
		end
		chk("kicked", 1'b0, crst);
		wt(1'b1, 400, c);
		chk("wdt_min", 1'b1, c >= (WDT_T - 2) * RC);
		chk("wdt_max", 1'b1, c <= (WDT_T + 2) * RC);
		wr(6'h08, 8'h00);
		wt(1'b0, 500, c);
		wb(1'b0, 6'h0C, 8'h00, q);
		chk("wdt_stat", 1'b1, q[2]);
		// Power loss in mid-run
		pg <= 1'b0;
		tk(10);
		chk("cold_hold", 1'b1, crst);
		pg <= 1'b1;
		wt(1'b0, 500, c);
		rd(6'h04, 8'h00);
		rd(6'h14, 8'h00);
		rd(6'h10, 8'h00);
		rd(6'h2C, 8'h20);
		// Second reset in mid-run
		wr(6'h2C, 8'h22);
		sys_rst <= 1'b1;
		tk(2);
		sys_rst <= 1'b0;
		tk(1);
		chk("rst_hold", 1'b1, crst);
		chk("rst_ack", 1'b0, ack);
		wt(1'b0, 500, c);
		chk("rst_rel", 1'b0, crst);
		rd(6'h2C, 8'h20);
		summarize();
	end
endmodule
`default_nettype wire
